// ==== logic/ufc_pkg.sv ====
// shared constants for the uart fifo control and dma request block
package ufc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 7;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_INT_IDENT  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR  = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 4'hA;

    // fifo control fields
    localparam int FC_FIFO_EN  = 0;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_TX_TRIG  = 4;
    localparam int FC_RX_TRIG  = 6;

    // interrupt enable fields
    localparam int IE_RX_AVAIL = 0;
    localparam int IE_TX_EMPTY = 1;

    // event status bits
    localparam int EV_RX_TRIG = 0;
    localparam int EV_RX_TMO  = 1;
    localparam int EV_TX_EMPTY = 2;
    localparam int EV_W        = 3;

    // reset values
    localparam logic [1:0] RST_RX_TRIG   = 2'h0;
    localparam logic [1:0] RST_TX_TRIG   = 2'h0;
    localparam logic       RST_DMA_MODE  = 1'b0;
    localparam logic       RST_FIFO_EN   = 1'b0;
    localparam logic [1:0] RST_INT_EN    = 2'h0;
    localparam logic [EV_W-1:0] RST_EVT  = 3'h0;

    // interrupt identification codes, bits 3:0
    localparam logic [3:0] ID_NONE    = 4'h1;
    localparam logic [3:0] ID_RX_TMO  = 4'hC;
    localparam logic [3:0] ID_RX_DATA = 4'h4;
    localparam logic [3:0] ID_TX_RDY  = 4'h2;

    // receive trigger levels, 16-byte variant
    localparam logic [CNT_W-1:0] RX16_LVL3 = 7'd14;
    localparam logic [CNT_W-1:0] RX16_LVL2 = 7'd8;
    localparam logic [CNT_W-1:0] RX16_LVL1 = 7'd4;
    localparam logic [CNT_W-1:0] RX16_LVL0 = 7'd1;
    // receive trigger levels, 64-byte variant
    localparam logic [CNT_W-1:0] RX64_LVL3 = 7'd60;
    localparam logic [CNT_W-1:0] RX64_LVL2 = 7'd56;
    localparam logic [CNT_W-1:0] RX64_LVL1 = 7'd16;
    localparam logic [CNT_W-1:0] RX64_LVL0 = 7'd8;
    // transmit thresholds, 64-byte variant
    localparam logic [CNT_W-1:0] TX64_LVL3 = 7'd56;
    localparam logic [CNT_W-1:0] TX64_LVL2 = 7'd32;
    localparam logic [CNT_W-1:0] TX64_LVL1 = 7'd16;
    localparam logic [CNT_W-1:0] TX64_LVL0 = 7'd8;

    // receive timeout: character times plus extra bit times
    localparam int TMO_CHARS      = 4;
    localparam int TMO_EXTRA_BITS = 12;
    localparam int TMO_W          = 8;

endpackage : ufc_pkg

// ==== logic/ufc_rx_timer.sv ====
// receive timeout timer counting bit times while the receive fifo waits
`timescale 1ns/1ps
module ufc_rx_timer
    import ufc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       bit_tick_in,
    input  wire logic       restart_in,
    input  wire logic       armed_in,
    input  wire logic [3:0] char_bits_in,
    output logic            timeout_out
);

    logic [TMO_W-1:0] count_q;
    logic [TMO_W-1:0] count_d;
    logic             fired_q;
    logic             fired_d;
    logic             timeout_d;
    logic [TMO_W-1:0] limit;
    logic             at_limit;

    // four character times plus twelve bit times
    assign limit = TMO_W'(TMO_CHARS * int'(char_bits_in) + TMO_EXTRA_BITS);
    assign at_limit = (count_q >= limit);

    always_comb begin
        count_d   = count_q;
        fired_d   = fired_q;
        timeout_d = 1'b0;
        if (restart_in || !armed_in) begin
            count_d = '0;
            fired_d = 1'b0;
        end else if (at_limit) begin
            timeout_d = !fired_q;
            fired_d   = 1'b1;
        end else if (bit_tick_in) begin
            count_d = count_q + TMO_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q     <= '0;
            fired_q     <= 1'b0;
            timeout_out <= 1'b0;
        end else if (ce_in) begin
            count_q     <= count_d;
            fired_q     <= fired_d;
            timeout_out <= timeout_d;
        end
    end

endmodule : ufc_rx_timer

// ==== logic/ufc_top.sv ====
// fifo control register, interrupt identity and dma request pins
`timescale 1ns/1ps
module ufc_top
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic [CNT_W-1:0]  rx_count_in,
    input  wire logic [CNT_W-1:0]  tx_count_in,
    input  wire logic              rx_pop_in,
    input  wire logic              rx_push_in,
    input  wire logic              bit_tick_in,
    input  wire logic [3:0]        char_bits_in,
    output logic [DATA_W-1:0]      rd_data_out,
    output logic                   rx_dma_request_n_out,
    output logic                   tx_dma_request_n_out,
    output logic                   rx_avail_irq_out,
    output logic                   irq_out,
    output logic                   fifo_en_out
);

    localparam bit                DEEP     = (FIFO_DEPTH > 16);
    localparam logic [CNT_W-1:0]  DEPTH_C  = CNT_W'(FIFO_DEPTH);

    // receive trigger level decode for both variants
    function automatic logic [CNT_W-1:0] rx_trig_level(
        input logic [1:0] sel,
        input bit         deep
    );
        logic [CNT_W-1:0] lvl;
        lvl = RX16_LVL0;
        if (deep) begin
            case (sel)
                2'h3:    lvl = RX64_LVL3;
                2'h2:    lvl = RX64_LVL2;
                2'h1:    lvl = RX64_LVL1;
                default: lvl = RX64_LVL0;
            endcase
        end else begin
            case (sel)
                2'h3:    lvl = RX16_LVL3;
                2'h2:    lvl = RX16_LVL2;
                2'h1:    lvl = RX16_LVL1;
                default: lvl = RX16_LVL0;
            endcase
        end
        return lvl;
    endfunction : rx_trig_level

    function automatic logic [CNT_W-1:0] tx_trig_level(
        input logic [1:0] sel
    );
        logic [CNT_W-1:0] lvl;
        case (sel)
            2'h3:    lvl = TX64_LVL3;
            2'h2:    lvl = TX64_LVL2;
            2'h1:    lvl = TX64_LVL1;
            default: lvl = TX64_LVL0;
        endcase
        return lvl;
    endfunction : tx_trig_level

    // control state
    logic                 fifo_en_q;
    logic                 fifo_en_d;
    logic                 dma_mode_q;
    logic                 dma_mode_d;
    logic [1:0]           rx_trig_q;
    logic [1:0]           rx_trig_d;
    logic [1:0]           tx_trig_q;
    logic [1:0]           tx_trig_d;
    logic [1:0]           int_en_q;
    logic [1:0]           int_en_d;
    logic [EV_W-1:0]      evt_status_q;
    logic [EV_W-1:0]      evt_status_d;
    logic [EV_W-1:0]      evt_enable_q;
    logic [EV_W-1:0]      evt_enable_d;
    logic                 rx_req_q;
    logic                 rx_req_d;
    logic                 tx_req_q;
    logic                 tx_req_d;
    logic                 at_trig_q;
    logic                 tx_empty_q;
    logic [DATA_W-1:0]    rd_data_d;

    // address decode
    logic wr_fifo_ctrl;
    logic wr_int_en;
    logic wr_evt_clear;
    logic wr_evt_enable;
    logic rd_int_ident;
    logic rd_int_en;
    logic rd_evt_status;
    logic rd_evt_enable;

    assign wr_fifo_ctrl  = wr_in && (addr_in == OFS_FIFO_CTRL);
    assign wr_int_en     = wr_in && (addr_in == OFS_INT_ENABLE);
    assign wr_evt_clear  = wr_in && (addr_in == OFS_EVT_CLEAR);
    assign wr_evt_enable = wr_in && (addr_in == OFS_EVT_ENABLE);
    assign rd_int_ident  = rd_in && (addr_in == OFS_INT_IDENT);
    assign rd_int_en     = rd_in && (addr_in == OFS_INT_ENABLE);
    assign rd_evt_status = rd_in && (addr_in == OFS_EVT_STATUS);
    assign rd_evt_enable = rd_in && (addr_in == OFS_EVT_ENABLE);

    // fifo status
    logic [CNT_W-1:0] rx_level;
    logic [CNT_W-1:0] tx_level;
    logic [CNT_W-1:0] tx_space;
    logic             rx_any;
    logic             rx_at_trig;
    logic             rx_hit_trig;
    logic             tx_empty;
    logic             tx_full;
    logic             tx_room;
    logic             mode1;
    logic             rx_timeout;

    assign rx_level    = rx_trig_level(rx_trig_q, DEEP);
    assign tx_level    = tx_trig_level(tx_trig_q);
    assign tx_space    = DEPTH_C - tx_count_in;
    assign rx_any      = (rx_count_in != '0);
    assign rx_at_trig  = fifo_en_q && (rx_count_in >= rx_level);
    assign rx_hit_trig = fifo_en_q && (rx_count_in == rx_level);
    assign tx_empty    = (tx_count_in == '0);
    assign tx_full     = (tx_count_in >= DEPTH_C);
    assign tx_room     = DEEP ? (tx_space > tx_level) : tx_empty;
    assign mode1       = fifo_en_q && dma_mode_q;

    ufc_rx_timer u_rx_timer (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .bit_tick_in  (bit_tick_in),
        .restart_in   (rx_pop_in || rx_push_in),
        .armed_in     (fifo_en_q && rx_any),
        .char_bits_in (char_bits_in),
        .timeout_out  (rx_timeout)
    );

    // fifo control write: other bits only taken with enable set
    always_comb begin
        fifo_en_d  = fifo_en_q;
        dma_mode_d = dma_mode_q;
        rx_trig_d  = rx_trig_q;
        tx_trig_d  = tx_trig_q;
        if (wr_fifo_ctrl) begin
            fifo_en_d = wr_data_in[FC_FIFO_EN];
            if (wr_data_in[FC_FIFO_EN]) begin
                dma_mode_d = wr_data_in[FC_DMA_MODE];
                rx_trig_d  = wr_data_in[FC_RX_TRIG +: 2];
                tx_trig_d  = DEEP ? wr_data_in[FC_TX_TRIG +: 2] : tx_trig_q;
            end
        end
    end

    assign int_en_d     = wr_int_en ? wr_data_in[1:0] : int_en_q;
    assign evt_enable_d = wr_evt_enable ? wr_data_in[EV_W-1:0]
                                        : evt_enable_q;

    // receive dma request
    always_comb begin
        rx_req_d = rx_req_q;
        if (!mode1) begin
            rx_req_d = rx_any;
        end else if (!rx_any) begin
            rx_req_d = 1'b0;
        end else if (rx_hit_trig || rx_timeout) begin
            rx_req_d = 1'b1;
        end
    end

    // transmit dma request
    always_comb begin
        tx_req_d = tx_req_q;
        if (!mode1) begin
            tx_req_d = tx_empty;
        end else if (tx_full) begin
            tx_req_d = 1'b0;
        end else if (tx_room) begin
            tx_req_d = 1'b1;
        end
    end

    // sticky events: set wins over clear
    logic [EV_W-1:0] evt_set;
    logic [EV_W-1:0] evt_clr;

    assign evt_set[EV_RX_TRIG]  = rx_at_trig && !at_trig_q;
    assign evt_set[EV_RX_TMO]   = rx_timeout;
    assign evt_set[EV_TX_EMPTY] = tx_empty && !tx_empty_q;
    assign evt_clr              = wr_evt_clear ? wr_data_in[EV_W-1:0]
                                               : '0;
    assign evt_status_d         = (evt_status_q & ~evt_clr) | evt_set;

    // interrupt identification
    logic       rx_avail_irq;
    logic       tmo_irq;
    logic       tx_irq;
    logic       tmo_pend_q;
    logic       tmo_pend_d;
    logic [3:0] ident;

    assign rx_avail_irq = rx_at_trig && int_en_q[IE_RX_AVAIL];
    assign tmo_pend_d   = rx_timeout ? 1'b1
                        : ((rx_pop_in || !rx_any) ? 1'b0 : tmo_pend_q);
    assign tmo_irq      = tmo_pend_q && int_en_q[IE_RX_AVAIL];
    assign tx_irq       = tx_empty && int_en_q[IE_TX_EMPTY];
    assign ident        = tmo_irq      ? ID_RX_TMO
                        : rx_avail_irq ? ID_RX_DATA
                        : tx_irq       ? ID_TX_RDY
                        : ID_NONE;

    // read data mux
    logic [DATA_W-1:0] ident_word;

    assign ident_word = {fifo_en_q, fifo_en_q, 2'b00, ident};
    assign rd_data_d  = rd_int_ident  ? ident_word
                      : rd_int_en     ? {6'h00, int_en_q}
                      : rd_evt_status ? {5'h00, evt_status_q}
                      : rd_evt_enable ? {5'h00, evt_enable_q}
                      : '0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fifo_en_q  <= RST_FIFO_EN;
            dma_mode_q <= RST_DMA_MODE;
            rx_trig_q  <= RST_RX_TRIG;
            tx_trig_q  <= RST_TX_TRIG;
            int_en_q   <= RST_INT_EN;
        end else if (ce_in) begin
            fifo_en_q  <= fifo_en_d;
            dma_mode_q <= dma_mode_d;
            rx_trig_q  <= rx_trig_d;
            tx_trig_q  <= tx_trig_d;
            int_en_q   <= int_en_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_status_q <= RST_EVT;
            evt_enable_q <= RST_EVT;
            at_trig_q    <= 1'b0;
            // transmit side is idle empty after reset: no false empty event
            tx_empty_q   <= 1'b1;
            tmo_pend_q   <= 1'b0;
        end else if (ce_in) begin
            evt_status_q <= evt_status_d;
            evt_enable_q <= evt_enable_d;
            at_trig_q    <= rx_at_trig;
            tx_empty_q   <= tx_empty;
            tmo_pend_q   <= tmo_pend_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_req_q             <= 1'b0;
            tx_req_q             <= 1'b0;
            rx_dma_request_n_out <= 1'b1;
            tx_dma_request_n_out <= 1'b1;
        end else if (ce_in) begin
            rx_req_q             <= rx_req_d;
            tx_req_q             <= tx_req_d;
            rx_dma_request_n_out <= !rx_req_d;
            tx_dma_request_n_out <= !tx_req_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out      <= '0;
            rx_avail_irq_out <= 1'b0;
            irq_out          <= 1'b0;
            fifo_en_out      <= RST_FIFO_EN;
        end else if (ce_in) begin
            rd_data_out      <= rd_data_d;
            rx_avail_irq_out <= rx_avail_irq;
            irq_out          <= |(evt_status_d & evt_enable_d);
            fifo_en_out      <= fifo_en_d;
        end
    end

endmodule : ufc_top

// ==== sim/ufc_checker.sv ====
// concurrent checks on the fifo control and dma request ports
`timescale 1ns/1ps
module ufc_checker
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)
(
    input wire logic              clk_in,
    input wire logic              rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [CNT_W-1:0]  rx_count_in,
    input wire logic [CNT_W-1:0]  tx_count_in,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic              rx_dma_request_n_out,
    input wire logic              tx_dma_request_n_out,
    input wire logic              rx_avail_irq_out,
    input wire logic              fifo_en_out
);
    logic             en_q, dma_q, ie_q, m1, wctl, avail_c;
    logic [1:0]       trig_q, live_q;
    logic [CNT_W-1:0] lvl;
    assign wctl = wr_in && addr_in == OFS_FIFO_CTRL;
    assign m1 = en_q && dma_q;
    assign lvl = (FIFO_DEPTH == 64)
        ? (trig_q[1] ? (trig_q[0] ? RX64_LVL3 : RX64_LVL2)
                     : (trig_q[0] ? RX64_LVL1 : RX64_LVL0))
        : (trig_q[1] ? (trig_q[0] ? RX16_LVL3 : RX16_LVL2)
                     : (trig_q[0] ? RX16_LVL1 : RX16_LVL0));
    assign avail_c = en_q && rx_count_in >= lvl && ie_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {en_q, dma_q, ie_q, trig_q, live_q} <= '0;
        end else begin
            if (live_q != 2'h3)
                live_q <= live_q + 2'h1;
            if (wctl)
                en_q <= wr_data_in[FC_FIFO_EN];
            if (wctl && wr_data_in[FC_FIFO_EN]) begin
                dma_q  <= wr_data_in[FC_DMA_MODE];
                trig_q <= wr_data_in[FC_RX_TRIG +: 2];
            end
            if (wr_in && addr_in == OFS_INT_ENABLE)
                ie_q <= wr_data_in[IE_RX_AVAIL];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_rd_idle_zero: assert property (live_q == 2'h3 && !rd_in |=>
        rd_data_out == 8'h00) else $error("read data not zero when idle");
    a_ident_en_bits: assert property (rd_in && addr_in == OFS_INT_IDENT
        |=> rd_data_out[7:6] == {2{$past(fifo_en_out)}})
        else $error("identity enable bits wrong");
    a_fifo_en_load: assert property (wctl |=>
        fifo_en_out == $past(wr_data_in[FC_FIFO_EN]))
        else $error("fifo enable not loaded");
    a_rx_single_req: assert property (live_q == 2'h3 && !m1 ##1 !m1 |->
        rx_dma_request_n_out == ($past(rx_count_in) == 0))
        else $error("single mode receive request wrong");
    a_tx_single_req: assert property (live_q == 2'h3 && !m1 ##1 !m1 |->
        tx_dma_request_n_out == ($past(tx_count_in) != 0))
        else $error("single mode transmit request wrong");
    a_rx_at_trig: assert property (m1 && rx_count_in == lvl ##1 m1
        |-> !rx_dma_request_n_out) else $error("no request at trigger");
    a_rx_hold_req: assert property (m1 && !rx_dma_request_n_out &&
        rx_count_in != 0 ##1 m1 |-> !rx_dma_request_n_out)
        else $error("block request dropped early");
    a_rx_empty_free: assert property (m1 && rx_count_in == 0 ##1 m1
        |-> rx_dma_request_n_out) else $error("request kept when empty");
    a_tx_empty_req: assert property (m1 && tx_count_in == 0 ##1 m1
        |-> !tx_dma_request_n_out) else $error("no transmit request");
    a_tx_full_free: assert property (m1 && tx_count_in >= FIFO_DEPTH
        ##1 m1 |-> tx_dma_request_n_out) else $error("request when full");
    a_avail_irq_lvl: assert property (live_q == 2'h3 |->
        rx_avail_irq_out == $past(avail_c)) else $error("avail irq wrong");
    c_rx_block: cover property (m1 && !rx_dma_request_n_out);
    c_tx_full: cover property (m1 && tx_dma_request_n_out);
    c_avail: cover property (rx_avail_irq_out);
endmodule : ufc_checker

bind ufc_top ufc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rx_count_in(rx_count_in), .tx_count_in(tx_count_in),
    .rd_data_out(rd_data_out), .rx_dma_request_n_out(rx_dma_request_n_out),
    .tx_dma_request_n_out(tx_dma_request_n_out),
    .rx_avail_irq_out(rx_avail_irq_out), .fifo_en_out(fifo_en_out));

// ==== sim/ufc_dma_model.sv ====
// dma controller and fifo occupancy model on the far side
`timescale 1ns/1ps
module ufc_dma_model
    import ufc_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             rx_req_n_in,
    input  wire logic             tx_req_n_in,
    input  wire logic             arrive_in,
    input  wire logic             send_in,
    input  wire logic             rx_serve_in,
    input  wire logic             tx_serve_in,
    output logic [CNT_W-1:0]      rx_count_out,
    output logic [CNT_W-1:0]      tx_count_out,
    output logic                  rx_pop_out,
    output logic                  rx_push_out
);
    logic fill, drain;
    assign rx_push_out = arrive_in;
    assign rx_pop_out = rx_serve_in && !rx_req_n_in && rx_count_out != 0;
    assign fill = tx_serve_in && !tx_req_n_in && tx_count_out < DEPTH;
    assign drain = send_in && tx_count_out != 0;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_count_out <= '0;
            tx_count_out <= '0;
        end else begin
            rx_count_out <= rx_count_out + CNT_W'(arrive_in)
                - CNT_W'(rx_pop_out);
            tx_count_out <= tx_count_out + CNT_W'(fill) - CNT_W'(drain);
        end
    end
endmodule : ufc_dma_model

// ==== sim/tb_uart_fifo_control_dma_request.sv ====
// self-checking bench for the fifo control and dma request block
`timescale 1ns/1ps
module tb_uart_fifo_control_dma_request;
    import ufc_pkg::*;
    localparam int DEPTH = 16;
    logic              clk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0, rd = 1'b0, arrive = 1'b0, send = 1'b0;
    logic              rx_serve = 1'b0, tx_serve = 1'b0, tick = 1'b0;
    logic [1:0]        tdiv = 2'h0;
    logic [CNT_W-1:0]  rx_cnt, tx_cnt;
    logic              pop, push, rx_req_n, tx_req_n, avail, irq, fen;
    logic [DATA_W-1:0] rdata, d;
    int                fails = 0, n_tests = 0, cycles = 0;
    logic [CNT_W-1:0]  lvl [4] = '{RX16_LVL0, RX16_LVL1, RX16_LVL2, RX16_LVL3};

    ufc_top #(.FIFO_DEPTH(DEPTH)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(1'b1), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr),
        .rd_in(rd), .rx_count_in(rx_cnt), .tx_count_in(tx_cnt),
        .rx_pop_in(pop), .rx_push_in(push), .bit_tick_in(tick),
        .char_bits_in(4'hA), .rd_data_out(rdata),
        .rx_dma_request_n_out(rx_req_n), .tx_dma_request_n_out(tx_req_n),
        .rx_avail_irq_out(avail), .irq_out(irq), .fifo_en_out(fen));
    ufc_dma_model #(.DEPTH(DEPTH)) mdl_u (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .rx_req_n_in(rx_req_n), .tx_req_n_in(tx_req_n),
        .arrive_in(arrive), .send_in(send), .rx_serve_in(rx_serve),
        .tx_serve_in(tx_serve), .rx_count_out(rx_cnt),
        .tx_count_out(tx_cnt), .rx_pop_out(pop), .rx_push_out(push));

    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            test_done();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        v = rdata;
    endtask : rreg
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic pulse(input bit tx);
        @(posedge clk_in);
        if (tx) send <= 1'b1; else arrive <= 1'b1;
        @(posedge clk_in);
        {send, arrive} <= 2'b00;
    endtask : pulse
    task automatic serve(input logic r, input logic t);
        @(posedge clk_in);
        rx_serve <= r;
        tx_serve <= t;
    endtask : serve
    task test_done;
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rreg(OFS_INT_IDENT, d);
        check(d, 8'h01);
        rreg(4'hF, d);
        check(d, 8'h00);
        wreg(OFS_FIFO_CTRL, 8'hC8);
        cyc(1);
        check(fen, 1'b0);
        wreg(OFS_FIFO_CTRL, 8'h01);
        rreg(OFS_INT_IDENT, d);
        check(d[7:6], 2'h3);
        pulse(0);
        cyc(3);
        check(rx_req_n, 1'b0);
        check(tx_req_n, 1'b0);
        serve(1, 1);
        cyc(6);
        check(rx_req_n, 1'b1);
        check(tx_req_n, 1'b1);
        serve(0, 0);
        wreg(OFS_INT_ENABLE, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wreg(OFS_FIFO_CTRL, {c[1:0], 6'b001001});
            for (int k = 1; k <= lvl[c]; k++) begin
                pulse(0);
                cyc(2);
                check(rx_req_n, k < lvl[c]);
            end
            check(avail, 1'b1);
            if (c == 3) begin
                rreg(OFS_INT_IDENT, d);
                check(d, 8'hC4);
                rreg(OFS_EVT_STATUS, d);
                check(d & 8'h01, 8'h01);
                wreg(OFS_EVT_ENABLE, 8'h01);
                cyc(2);
                check(irq, 1'b1);
                wreg(OFS_EVT_CLEAR, 8'h01);
                cyc(2);
                check(irq, 1'b0);
            end
            serve(1, 0);
            cyc(lvl[c] + 4);
            check(rx_cnt, 0);
            check(rx_req_n, 1'b1);
            check(avail, 1'b0);
            serve(0, 0);
        end
        repeat (4) pulse(1);
        cyc(2);
        check(tx_req_n, 1'b0);
        wreg(OFS_INT_ENABLE, 8'h03);
        rreg(OFS_INT_IDENT, d);
        check(d, 8'hC2);
        serve(0, 1);
        cyc(DEPTH + 4);
        check(tx_cnt, DEPTH);
        check(tx_req_n, 1'b1);
        pulse(1);
        cyc(3);
        check(tx_req_n, 1'b1);
        serve(0, 0);
        wreg(OFS_FIFO_CTRL, 8'h49);
        pulse(0);
        cyc(180);
        check(rx_req_n, 1'b1);
        cyc(80);
        check(rx_req_n, 1'b0);
        rreg(OFS_EVT_STATUS, d);
        check(d & 8'h02, 8'h02);
        rreg(OFS_INT_IDENT, d);
        check(d, 8'hCC);
        serve(1, 0);
        cyc(4);
        serve(0, 0);
        wreg(OFS_FIFO_CTRL, 8'h08);
        pulse(0);
        cyc(3);
        check(rx_req_n, 1'b0);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rreg(OFS_INT_IDENT, d);
        check(d, 8'h01);
        test_done();
    end
endmodule : tb_uart_fifo_control_dma_request
